// ### pidr_pkg.sv
/*
 * Constants, encodings and types of the process regulator.
 * Assumes a 200 MHz mclk; percent values are in 0.01 % steps, band and level limits in 0.1 % steps.
 */
package pidr_pkg;
   //----------------------------------------
   // timing
   //----------------------------------------
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned PERIOD_US    = 1000;
   localparam int unsigned PERIOD_CYC   = CLK_HZ / 1_000_000 * PERIOD_US;
   localparam int unsigned PERIOD_MS    = PERIOD_US / 1000;
   // periods per 0.1 s step and per 0.01 s step
   localparam int unsigned TENTH_PER    = 100 / PERIOD_MS;
   localparam int unsigned HUNDREDTH_PER = 10 / PERIOD_MS;
   //----------------------------------------
   // modes and codes
   //----------------------------------------
   localparam logic [7:0] REG_BYPASS    = 8'h00;
   localparam logic [7:0] REG_NORMAL    = 8'h01;
   localparam logic [7:0] REG_INVERT    = 8'h02;
   localparam logic [7:0] FB_ANALOG     = 8'h01;
   localparam logic [7:0] FB_SERIAL     = 8'h02;
   localparam logic [7:0] FB_ARITH      = 8'h0a;
   localparam logic [7:0] SRC_TERMINAL  = 8'h01;
   localparam logic [7:0] SRC_OPERATOR  = 8'h02;
   localparam logic [7:0] SRC_SERIAL    = 8'h03;
   localparam logic [7:0] SRC_ARITH     = 8'h0a;
   localparam logic [7:0] FN_DISABLE    = 8'h17;
   localparam logic [7:0] FN_INT_CLEAR  = 8'h18;
   localparam logic [7:0] FN_DEV_FLAG   = 8'h04;
   localparam logic [7:0] FN_FB_WINDOW  = 8'h1f;
   localparam logic [7:0] POL_INVERT    = 8'h01;
   //----------------------------------------
   // register and ranges
   //----------------------------------------
   localparam logic [15:0] FB_REG_ADDR  = 16'h0006;
   localparam logic [15:0] FB_REG_RESET = 16'h0000;
   localparam logic [15:0] FULL_SCALE   = 16'h2710;
   localparam logic [15:0] KP_MIN       = 16'h0002;
   localparam logic [15:0] KP_MAX       = 16'h00fa;
   localparam logic [15:0] TI_MAX       = 16'h8ca0;
   localparam logic [15:0] TD_MAX       = 16'h2710;
   localparam logic [15:0] SCALE_MIN    = 16'h0001;
   localparam logic [15:0] SCALE_MAX    = 16'h270f;
   localparam logic [15:0] LEVEL_MAX    = 16'h03e8;
   localparam logic [15:0] HZ_MAX       = 16'h0fa0;
   localparam logic [7:0]  DLY_MAX      = 8'hff;
   localparam int          NTERM        = 5;

   typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_SUM} pidr_state_t;
endpackage

// ### pidr_divider.sv
/*
 * Unsigned serial divider, one quotient bit per clock.
 * Assumes a nonzero divisor; done pulses 33 cycles after start.
 */
`timescale 1ns/1ps
module pidr_divider (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // request
   input  wire logic        start,
   input  wire logic [31:0] dividend,
   input  wire logic [23:0] divisor,
   // answer
   output logic             done,
   output logic [31:0]      quotient
);
   logic [24:0] rem_reg;
   logic [31:0] quo_reg;
   logic [23:0] dsr_reg;
   logic [5:0]  cnt_reg;
   logic [24:0] shifted;
   logic [24:0] diff;

   assign shifted  = {rem_reg[23:0], quo_reg[31]};
   assign diff     = shifted - {1'b0, dsr_reg};
   assign quotient = quo_reg;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rem_reg <= 25'h0000000;
         quo_reg <= 32'h00000000;
         dsr_reg <= 24'h000000;
         cnt_reg <= 6'h00;
         done    <= 1'b0;
      end else if (start) begin
         rem_reg <= 25'h0000000;
         quo_reg <= dividend;
         dsr_reg <= divisor;
         cnt_reg <= 6'h20;
         done    <= 1'b0;
      end else if (cnt_reg != 6'h00) begin
         rem_reg <= diff[24] ? shifted : diff;
         quo_reg <= {quo_reg[30:0], ~diff[24]};
         cnt_reg <= cnt_reg - 6'h01;
         done    <= (cnt_reg == 6'h01);
      end else begin
         done    <= 1'b0;
      end
   end
endmodule

// ### pidr_regulator.sv
/*
 * Process regulator: deviation, P/I/D correction, output shaping,
 * sleep control, flags and the serial feedback holding register.
 * Assumes percent inputs are synchronous words in 0.01 % steps (band, alarm and compare levels in 0.1 %);
 * terminal pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
module pidr_regulator
#(
   parameter int unsigned PERIOD = pidr_pkg::PERIOD_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // settings
   input  wire logic [7:0]  regulator_enable_select,
   input  wire logic [15:0] proportional_gain,
   input  wire logic [15:0] integral_time,
   input  wire logic [15:0] derivative_time,
   input  wire logic [15:0] feedback_display_scale,
   input  wire logic [7:0]  feedback_source_select,
   input  wire logic [7:0]  deviation_polarity_invert,
   input  wire logic [15:0] output_band_limit,
   input  wire logic [15:0] sleep_threshold,
   input  wire logic [7:0]  sleep_delay,
   input  wire logic [15:0] wake_threshold,
   input  wire logic [15:0] deviation_alarm_level,
   input  wire logic [15:0] feedback_compare_off_level,
   input  wire logic [15:0] feedback_compare_on_level,
   input  wire logic [7:0]  frequency_source_select,
   input  wire logic [15:0] max_frequency,
   // process values
   input  wire logic [15:0] analog_feedback_input,
   input  wire logic [15:0] arith_result,
   input  wire logic [15:0] target_terminal,
   input  wire logic [15:0] target_operator,
   input  wire logic [15:0] target_serial,
   input  wire logic [15:0] ordinary_command,
   // terminals
   input  wire logic [4:0]  terminal_in,
   input  wire logic [7:0]  terminal_func [pidr_pkg::NTERM],
   input  wire logic [7:0]  out_terminal_func,
   output logic             out_terminal,
   // holding register port
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   output logic             reg_rd_ack,
   output logic             reg_rd_refused,
   // results
   output logic [15:0]      command_pct,
   output logic             output_stop,
   output logic             deviation_exceed_flag,
   output logic             feedback_window_flag,
   output logic [31:0]      feedback_monitor
);
   import pidr_pkg::*;

   //----------------------------------------
   // terminal synchronisers
   //----------------------------------------
   logic [4:0] s1_reg, s2_reg, s3_reg, lvl_reg;
   logic [4:0] dis_hit, clr_hit;
   logic       disable_term, clr_reg, clr_pulse;

   genvar gi;
   generate
      for (gi = 0; gi < NTERM; gi++) begin : g_term
         always_ff @(posedge mclk) begin
            if (!resetn) begin
               s1_reg[gi]  <= 1'b0;
               s2_reg[gi]  <= 1'b0;
               s3_reg[gi]  <= 1'b0;
               lvl_reg[gi] <= 1'b0;
            end else begin
               s1_reg[gi] <= terminal_in[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               if (s2_reg[gi] == s3_reg[gi]) begin
                  lvl_reg[gi] <= s3_reg[gi];
               end
            end
         end
         assign dis_hit[gi] = lvl_reg[gi] && (terminal_func[gi] == FN_DISABLE);
         assign clr_hit[gi] = lvl_reg[gi] && (terminal_func[gi] == FN_INT_CLEAR);
      end
   endgenerate

   assign disable_term = |dis_hit;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         clr_reg <= 1'b0;
      end else begin
         clr_reg <= |clr_hit;
      end
   end
   assign clr_pulse = (|clr_hit) && !clr_reg;

   //----------------------------------------
   // setting limits
   //----------------------------------------
   logic [15:0] kp_c, ti_c, td_c, scale_c, band_c, sthr_c, wthr_c;
   logic [15:0] alarm_c, on_c, off_c;

   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] lo,
                                       input logic [15:0] hi);
      lim = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   assign kp_c    = lim(proportional_gain, KP_MIN, KP_MAX);
   assign ti_c    = lim(integral_time, 16'h0000, TI_MAX);
   assign td_c    = lim(derivative_time, 16'h0000, TD_MAX);
   assign scale_c = lim(feedback_display_scale, SCALE_MIN, SCALE_MAX);
   assign band_c  = lim(output_band_limit, 16'h0000, LEVEL_MAX);
   assign sthr_c  = lim(sleep_threshold, 16'h0000, HZ_MAX);
   assign wthr_c  = lim(wake_threshold, sthr_c, HZ_MAX);
   assign alarm_c = lim(deviation_alarm_level, 16'h0000, LEVEL_MAX);
   assign on_c    = lim(feedback_compare_on_level, 16'h0000, LEVEL_MAX);
   assign off_c   = lim(feedback_compare_off_level, 16'h0000, LEVEL_MAX);

   //----------------------------------------
   // holding register
   //----------------------------------------
   logic [15:0] fb_reg;
   logic        hit;

   assign hit = (reg_addr == FB_REG_ADDR);

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fb_reg <= FB_REG_RESET;
      end else if (reg_wr && hit) begin
         fb_reg <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         reg_rdata      <= 16'h0000;
         reg_rd_ack     <= 1'b0;
         reg_rd_refused <= 1'b0;
      end else begin
         reg_rd_ack     <= reg_rd && hit && (feedback_source_select == FB_SERIAL);
         reg_rd_refused <= reg_rd && !(hit && (feedback_source_select == FB_SERIAL));
         if (reg_rd && hit && (feedback_source_select == FB_SERIAL)) begin
            reg_rdata <= fb_reg;
         end
      end
   end

   //----------------------------------------
   // target, feedback and deviation
   //----------------------------------------
   logic [15:0]        fb_raw, fb_pct, tgt_raw, tgt_pct, ord_pct;
   logic signed [17:0] dev;
   logic               regulating;

   always_comb begin
      case (feedback_source_select)
         FB_ANALOG: fb_raw = analog_feedback_input;
         FB_SERIAL: fb_raw = fb_reg;
         FB_ARITH:  fb_raw = arith_result;
         default:   fb_raw = 16'h0000;
      endcase
      case (frequency_source_select)
         SRC_TERMINAL: tgt_raw = target_terminal;
         SRC_SERIAL:   tgt_raw = target_serial;
         SRC_ARITH:    tgt_raw = arith_result;
         default:      tgt_raw = target_operator;
      endcase
   end

   assign fb_pct  = lim(fb_raw, 16'h0000, FULL_SCALE);
   assign tgt_pct = lim(tgt_raw, 16'h0000, FULL_SCALE);
   assign ord_pct = lim(ordinary_command, 16'h0000, FULL_SCALE);
   assign dev = (deviation_polarity_invert == POL_INVERT) ?
                $signed({2'b00, fb_pct}) - $signed({2'b00, tgt_pct}) :
                $signed({2'b00, tgt_pct}) - $signed({2'b00, fb_pct});
   assign regulating = ((regulator_enable_select == REG_NORMAL) ||
                        (regulator_enable_select == REG_INVERT)) && !disable_term;

   //----------------------------------------
   // control period and sequencing
   //----------------------------------------
   localparam logic signed [31:0] INT_LIM = 32'sh3fffffff;
   logic [31:0]        per_cnt;
   logic               tick;
   pidr_state_t        state;
   logic signed [17:0] e_reg, e_prev_reg;
   logic signed [31:0] integ_reg, integ_nx;
   logic signed [31:0] iq_s;
   logic signed [47:0] u_sum, u_scl;
   logic signed [31:0] u_reg;
   logic               div_start, div_done;
   logic [31:0]        div_q, div_a;

   assign tick = (per_cnt == PERIOD - 1);

   always_ff @(posedge mclk) begin
      if (!resetn || tick) begin
         per_cnt <= 32'h00000000;
      end else begin
         per_cnt <= per_cnt + 32'h00000001;
      end
   end

   always_comb begin
      integ_nx = integ_reg + 32'(dev);
      if (integ_nx > INT_LIM) begin
         integ_nx = INT_LIM;
      end else if (integ_nx < -INT_LIM) begin
         integ_nx = -INT_LIM;
      end
   end

   assign div_a     = integ_reg[31] ? 32'(-integ_reg) : 32'(integ_reg);
   assign div_start = (state == ST_IDLE) && tick && regulating && (ti_c != 16'h0000);

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state      <= ST_IDLE;
         e_reg      <= 18'sh00000;
         e_prev_reg <= 18'sh00000;
         integ_reg  <= 32'sh00000000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (clr_pulse || !regulating) begin
                  integ_reg <= 32'sh00000000;
               end
               if (tick && regulating) begin
                  e_prev_reg <= e_reg;
                  e_reg      <= dev;
                  if (!clr_pulse) begin
                     integ_reg <= integ_nx;
                  end
                  state <= (ti_c != 16'h0000) ? ST_DIV : ST_SUM;
               end
            end
            ST_DIV: begin
               if (clr_pulse) begin
                  integ_reg <= 32'sh00000000;
               end
               if (div_done) begin
                  state <= ST_SUM;
               end
            end
            ST_SUM: begin
               if (clr_pulse) begin
                  integ_reg <= 32'sh00000000;
               end
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   pidr_divider u_div (
      .mclk     (mclk),
      .resetn   (resetn),
      .start    (div_start),
      .dividend (div_a),
      .divisor  (24'(ti_c) * 24'(TENTH_PER)),
      .done     (div_done),
      .quotient (div_q)
   );

   //----------------------------------------
   // correction
   //----------------------------------------
   logic signed [31:0] iq_c;
   assign iq_c = (ti_c == 16'h0000) ? 32'sh00000000 :
                 ((div_q > 32'h00004e20) ? 32'sh00004e20 : $signed(div_q));
   assign iq_s = integ_reg[31] ? -iq_c : iq_c;
   assign u_sum = 48'(e_reg) + 48'(iq_s) +
                  48'(td_c) * 48'(HUNDREDTH_PER) * 48'(e_reg - e_prev_reg);
   // signed divide so a negative sum keeps its sign
   assign u_scl = ($signed(48'(kp_c)) * u_sum) / 48'sd10;

   always_ff @(posedge mclk) begin
      if (!resetn || !regulating) begin
         u_reg <= 32'sh00000000;
      end else if (state == ST_SUM) begin
         if (u_scl > 48'sh000000007fff) begin
            u_reg <= 32'sh00007fff;
         end else if (u_scl < -48'sh000000007fff) begin
            u_reg <= -32'sh00007fff;
         end else begin
            u_reg <= u_scl[31:0];
         end
      end
   end

   //----------------------------------------
   // output shaping
   //----------------------------------------
   logic signed [31:0] shaped, lo_b, hi_b;
   logic [15:0]        cmd_next;

   assign lo_b = 32'(tgt_pct) - 32'(band_c) * 32'sd10;
   assign hi_b = 32'(tgt_pct) + 32'(band_c) * 32'sd10;

   always_comb begin
      shaped = u_reg;
      if (u_reg < 0) begin
         shaped = (regulator_enable_select == REG_INVERT) ? -u_reg : 32'sh0;
      end
      if ((band_c != 16'h0000) && (regulator_enable_select != REG_INVERT)) begin
         if (shaped < lo_b) begin
            shaped = lo_b;
         end else if (shaped > hi_b) begin
            shaped = hi_b;
         end
      end
      if (shaped < 0) begin
         shaped = 32'sh0;
      end else if (shaped > 32'(FULL_SCALE)) begin
         shaped = 32'(FULL_SCALE);
      end
      cmd_next = regulating ? shaped[15:0] : ord_pct;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         command_pct <= 16'h0000;
      end else begin
         command_pct <= cmd_next;
      end
   end

   //----------------------------------------
   // sleep control
   //----------------------------------------
   logic [32:0] cmd_hz, sthr_hz, wthr_hz;
   logic [15:0] slp_cnt;
   logic        below, above;

   assign cmd_hz  = 33'(command_pct) * 33'(max_frequency);
   assign sthr_hz = 33'(sthr_c) * 33'd100000;
   assign wthr_hz = 33'(wthr_c) * 33'd100000;
   assign below   = cmd_hz < sthr_hz;
   assign above   = cmd_hz > wthr_hz;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         output_stop <= 1'b0;
         slp_cnt     <= 16'h0000;
      end else if (tick) begin
         if (output_stop ? above : below) begin
            if (slp_cnt >= 16'(sleep_delay) * 16'(TENTH_PER)) begin
               output_stop <= !output_stop;
               slp_cnt     <= 16'h0000;
            end else begin
               slp_cnt <= slp_cnt + 16'h0001;
            end
         end else begin
            slp_cnt <= 16'h0000;
         end
      end
   end

   //----------------------------------------
   // flags and monitor
   //----------------------------------------
   logic [17:0] dev_mag;
   assign dev_mag = dev[17] ? 18'(-dev) : 18'(dev);

   always_ff @(posedge mclk) begin
      if (!resetn || !regulating) begin
         deviation_exceed_flag <= 1'b0;
         feedback_window_flag  <= 1'b0;
      end else begin
         deviation_exceed_flag <= dev_mag > 18'(alarm_c) * 18'd10;
         if (fb_pct >= on_c * 16'd10) begin
            feedback_window_flag <= 1'b1;
         end else if (fb_pct <= off_c * 16'd10) begin
            feedback_window_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         feedback_monitor <= 32'h00000000;
         out_terminal     <= 1'b0;
      end else begin
         feedback_monitor <= 32'(fb_pct) * 32'(scale_c);
         out_terminal     <= (out_terminal_func == FN_DEV_FLAG) ? deviation_exceed_flag :
                             (out_terminal_func == FN_FB_WINDOW) && feedback_window_flag;
      end
   end

   //----------------------------------------
   // checks
   //----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   bypass_cmd_a: assert property (!regulating |=> command_pct == $past(ord_pct))
      else $error("bypass command mismatch");
   clamp_zero_a: assert property ((regulating && regulator_enable_select == REG_NORMAL &&
      band_c == 16'h0000 && u_reg < 0) |=> command_pct == 16'h0000)
      else $error("negative result not clamped");
   invert_neg_a: assert property ((regulating && regulator_enable_select == REG_INVERT &&
      u_reg < 0 && u_reg > -32'sh2710) |=> command_pct == $past(16'(-u_reg)))
      else $error("negative result not inverted");
   band_hold_a: assert property ((regulating && regulator_enable_select == REG_NORMAL &&
      band_c != 16'h0000) |=> ($signed(32'(command_pct)) >= $past(lo_b)) &&
      ($signed(32'(command_pct)) <= $past(hi_b)))
      else $error("command outside band");
   int_clear_a: assert property ((clr_pulse && state != ST_IDLE) |=> integ_reg == 0)
      else $error("integral not cleared");
   read_refuse_a: assert property ((reg_rd && feedback_source_select != FB_SERIAL)
      |=> reg_rd_refused && !reg_rd_ack)
      else $error("read not refused");
   flags_off_a: assert property (!regulating |=> !deviation_exceed_flag &&
      !feedback_window_flag)
      else $error("flag high while disabled");
   div_time_a: assert property ($rose(div_start) |-> ##33 div_done)
      else $error("divider late");
   sleep_cause_a: assert property ($rose(output_stop) |-> $past(below))
      else $error("sleep without low command");

   reg_cover_c: cover property (regulating && state == ST_SUM);
   sleep_cover_c: cover property ($rose(output_stop));
   clear_cover_c: cover property (clr_pulse && regulating);
endmodule

// ### pidr_sensor.sv
/*
 * process feedback sensor model feeding the analog feedback input.
 * assumes the bench sets the process value pv in 0.01 % steps.
 */
`timescale 1ns/1ps
module pidr_sensor (
   // clock
   input  wire logic        mclk,
   // process value and sensor output
   input  wire logic [15:0] pv,
   output logic [15:0]      analog_feedback_input
);
   import pidr_pkg::*;
   // sensor saturates at full scale
   always_ff @(posedge mclk) begin
      analog_feedback_input <= (pv > FULL_SCALE) ? FULL_SCALE : pv;
   end
endmodule

// ### pid_process_regulator_tb.sv
/*
 * testbench of pidr_regulator: register port, modes, terminals, flags.
 * assumes pidr_sensor as feedback source and a short control period.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pid_process_regulator_tb;
   import pidr_pkg::*;
   logic        mclk, resetn, rd, wr, out_t, ack, refd, stop, devf, winf;
   logic [7:0]  en, fsrc, pol, sd;
   logic [7:0]  tf [NTERM];
   logic [15:0] kp, ti, td, scl, band, slt, wkt, alm, fon, foff, mxf, tgt, pv, afb;
   logic [15:0] ordc, addr, wd, rdat, cmd;
   logic [4:0]  tin;
   logic [31:0] mon;
   int          n_fail, n_compared;
   pidr_sensor sens_u (.mclk(mclk), .pv(pv), .analog_feedback_input(afb));
   pidr_regulator #(.PERIOD(200)) dut_u (
      .mclk(mclk), .resetn(resetn), .regulator_enable_select(en), .proportional_gain(kp),
      .integral_time(ti), .derivative_time(td), .feedback_display_scale(scl),
      .feedback_source_select(fsrc), .deviation_polarity_invert(pol),
      .output_band_limit(band), .sleep_threshold(slt), .sleep_delay(sd),
      .wake_threshold(wkt), .deviation_alarm_level(alm), .feedback_compare_off_level(foff),
      .feedback_compare_on_level(fon), .frequency_source_select(8'h02), .max_frequency(mxf),
      .analog_feedback_input(afb), .arith_result(tgt), .target_terminal(tgt),
      .target_operator(tgt), .target_serial(tgt), .ordinary_command(ordc),
      .terminal_in(tin), .terminal_func(tf), .out_terminal_func(8'h04),
      .out_terminal(out_t), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
      .reg_rdata(rdat), .reg_rd_ack(ack), .reg_rd_refused(refd), .command_pct(cmd),
      .output_stop(stop), .deviation_exceed_flag(devf), .feedback_window_flag(winf),
      .feedback_monitor(mon));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic ok, input logic [15:0] d);
      @(posedge mclk) begin addr <= a; rd <= 1'b1; end
      @(posedge mclk) rd <= 1'b0;
      #1 `CHK(ack, ok)
      `CHK(refd, !ok)
      if (ok) `CHK(rdat, d)
   endtask
   task automatic pcase(input logic [7:0] e, p, input logic [15:0] k, b, t, f, c,
                        input logic d, w);
      @(posedge mclk) begin en <= e; pol <= p; kp <= k; band <= b; tgt <= t; pv <= f; end
      cyc(700);
      #1 `CHK(cmd, c)
      `CHK(devf, d)
      `CHK(out_t, d)
      `CHK(winf, w)
      `CHK(mon, {16'h0000, f} * 32'd100)
      `CHK(stop, 1'b0)
   endtask
   task automatic t_reg;
      @(posedge mclk) begin fsrc <= FB_SERIAL; addr <= FB_REG_ADDR; wd <= 16'h1388; end
      @(posedge mclk) wr <= 1'b1;
      @(posedge mclk) wr <= 1'b0;
      rd_chk(FB_REG_ADDR, 1'b1, 16'h1388);
      rd_chk(16'h0007, 1'b0, 16'h0000);
      @(posedge mclk) fsrc <= FB_ANALOG;
      rd_chk(FB_REG_ADDR, 1'b0, 16'h0000);
      $display("test reg done");
   endtask
   task automatic t_pid;
      pcase(REG_NORMAL, 8'h00, 16'h000a, 16'h0000, 16'h0fa0, 16'h03e8, 16'h0bb8, 1, 0);
      pcase(REG_NORMAL, 8'h00, 16'h000a, 16'h0000, 16'h07d0, 16'h05dc, 16'h01f4, 0, 0);
      $display("test pid done");
   endtask
   task automatic t_term;
      @(posedge mclk) begin tf[0] <= FN_DISABLE; tin[0] <= 1'b1; end
      cyc(10);
      #1 `CHK(cmd, ordc)
      @(posedge mclk) tin[0] <= 1'b0;
      cyc(700);
      #1 `CHK(cmd, 16'h01f4)
      $display("test terminal done");
   endtask
   task automatic t_neg;
      pcase(REG_NORMAL, 8'h00, 16'h000a, 16'h0000, 16'h03e8, 16'h0fa0, 16'h0000, 1, 1);
      pcase(REG_INVERT, 8'h00, 16'h000a, 16'h0000, 16'h03e8, 16'h0fa0, 16'h0bb8, 1, 1);
      pcase(REG_NORMAL, 8'h01, 16'h000a, 16'h0000, 16'h03e8, 16'h0fa0, 16'h0bb8, 1, 1);
      $display("test negative done");
   endtask
   task automatic t_byp;
      @(posedge mclk) en <= REG_BYPASS;
      cyc(5);
      #1 `CHK(cmd, ordc)
      `CHK(devf, 1'b0)
      `CHK(winf, 1'b0)
      $display("test bypass done");
   endtask
   task automatic t_band;
      pcase(REG_NORMAL, 8'h00, 16'h0032, 16'h0064, 16'h07d0, 16'h0000, 16'h0bb8, 1, 0);
      pcase(REG_NORMAL, 8'h00, 16'h0032, 16'h0000, 16'h07d0, 16'h0000, 16'h2710, 1, 0);
      pcase(REG_INVERT, 8'h00, 16'h0032, 16'h0064, 16'h07d0, 16'h0000, 16'h2710, 1, 0);
      $display("test band done");
   endtask
   task automatic complete_run;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #100000 n_fail++;
      complete_run;
   end
   initial begin
      resetn = 1'b0; rd = 1'b0; wr = 1'b0; addr = 16'h0000; wd = 16'h0000; tin = 5'h00;
      tf = '{default: 8'h00}; en = REG_NORMAL; pol = 8'h00; fsrc = FB_ANALOG; kp = 16'h000a;
      ti = 16'h0000; td = 16'h0000; scl = 16'h0064; band = 16'h0000; slt = 16'h0000;
      sd = 8'h00; wkt = 16'h0000; alm = 16'h0064; fon = 16'h0190; foff = 16'h00c8;
      mxf = 16'h9c40; tgt = 16'h0000; pv = 16'h0000; ordc = 16'h0457;
      n_fail = 0; n_compared = 0;
      cyc(2);
      resetn <= 1'b1;
      t_reg;
      t_pid;
      t_term;
      t_neg;
      t_byp;
      t_band;
      complete_run;
   end
endmodule
